// ### i2cdt_map.vh
// Register offsets, field positions and reset values for the two-wire data and timing block.
`ifndef I2CDT_MAP_VH
`define I2CDT_MAP_VH
`define I2CDT_OFF_CMD 8'h10
`define I2CDT_OFF_SS_HCNT 8'h14
`define I2CDT_OFF_SS_LCNT 8'h18
`define I2CDT_OFF_FS_HCNT 8'h1C
`define I2CDT_OFF_FS_LCNT 8'h20
`define I2CDT_OFF_HS_HCNT 8'h24
`define I2CDT_OFF_HS_LCNT 8'h28
`define I2CDT_OFF_STAT 8'h2C
`define I2CDT_OFF_MASK 8'h30
`define I2CDT_OFF_RAW 8'h34
`define I2CDT_OFF_RXTL 8'h38
`define I2CDT_OFF_TXTL 8'h3C
`define I2CDT_OFF_CLR 8'h40
`define I2CDT_OFF_CTRL 8'h00
`define I2CDT_CMD_BIT 8
`define I2CDT_CMD_READ 1'h0
`define I2CDT_CMD_WRITE 1'h1
`define I2CDT_FLAG_W 12
`define I2CDT_MASK_RST 12'h8FF
`define I2CDT_CNT_RST 16'h0000
`define I2CDT_TL_RST 8'h00
`define I2CDT_SPD_STD 2'h1
`define I2CDT_SPD_FAST 2'h2
`define I2CDT_SPD_HS 2'h3
`define I2CDT_CTRL_RST 3'h6
`define I2CDT_F_GEN_CALL 11
`define I2CDT_F_START 10
`define I2CDT_F_STOP 9
`define I2CDT_F_ACTIVITY 8
`define I2CDT_F_TX_DONE 7
`define I2CDT_F_TX_ABORT 6
`define I2CDT_F_RD_REQ 5
`define I2CDT_F_TX_EMPTY 4
`define I2CDT_F_TX_OVER 3
`define I2CDT_F_RX_FULL 2
`define I2CDT_F_RX_OVER 1
`define I2CDT_F_RX_UNDER 0
`endif

// ### i2cdt_regs.v
// Data-command port, SCL period counts, event flags and mask of a two-wire bus controller.
`default_nettype none
`include "i2cdt_map.vh"

// Function
// - Command bit 8 of a port write: 0 requests a read, 1 a write.
// - Port bits 7:0 carry the byte sent, and return the byte received on read.
// - Standard high count, 16 bits, resets to zero, times standard SCL high.
// - Standard low count, 16 bits, resets to zero, times standard SCL low.
// - Fast high count, 16 bits, resets to zero, times fast SCL high.
// - Fast low count, 16 bits, resets to zero, times fast SCL low.
// - High-speed high count, 16 bits, resets to zero, times high-speed SCL high.
// - High-speed low count, 16 bits, resets to zero, times high-speed SCL low.
// - General-call flag sets only when general call address is received and acknowledged.
// - Start flag sets on every START or repeated START.
// - Stop flag sets on every STOP.
// - Activity flag sets on bus activity and stays until cleared.
// - Slave-transmitter sets transmit-done when master does not acknowledge a byte.
// - Transmit-abort flag sets when queued transmit work cannot complete.
// - Read-request flag sets when addressed as slave and a master reads.
// - Transmit-empty flag set while transmit level is at or below threshold.
// - Transmit-overflow sets when a command is written with transmit queue full.
// - Receive-full flag set when receive level reaches or exceeds threshold.
// - Receive-overflow sets when a byte arrives with receive queue full.
// - Receive-underflow sets when software reads the port with receive queue empty.
// - Mask holds one bit per flag; reset pattern 12'h8FF.
// - Receive threshold, 8 bits, resets to zero, drives receive-full.
// - Transmit threshold, 8 bits, resets to zero, drives transmit-empty.
module i2cdt_regs #(
  parameter TX_DEPTH = 8,
  parameter RX_DEPTH = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  // Queue side: commands out, received bytes in.
  output wire cmdValid,
  output wire cmdIsWrite,
  output wire [7:0] cmdByte,
  input wire cmdTake,
  input wire [7:0] txLevel,
  input wire [7:0] rxLevel,
  output wire rxPop,
  input wire [7:0] rxByte,
  // Bus events from the protocol engine, each a one-cycle pulse.
  input wire evGenCall,
  input wire evStart,
  input wire evStop,
  input wire evActive,
  input wire evTxNack,
  input wire evTxAbort,
  input wire evRdReq,
  input wire evRxByte,
  // SCL generation and event interrupt.
  input wire sclRun,
  output reg sclOut,
  output reg [1:0] speedMode,
  output wire eventIrq
);

  wire [15:0] ssHigh_r;
  wire [15:0] ssLow_r;
  wire [15:0] fsHigh_r;
  wire [15:0] fsLow_r;
  wire [15:0] hsHigh_r;
  wire [15:0] hsLow_r;
  wire [11:0] mask_r;
  reg [11:0] raw_r;
  reg [11:0] raw_nxt;
  wire [7:0] rxTl_r;
  wire [7:0] txTl_r;
  wire [2:0] ctrl_r;
  reg [15:0] phaseCnt_r;
  reg [8:0] cmdWord_r;
  reg cmdPend_r;
  reg [15:0] highSel;
  reg [15:0] lowSel;

  wire txFull = (txLevel >= TX_DEPTH[7:0]) || cmdPend_r;
  wire rxEmpty = (rxLevel == 8'h00);
  wire rxFullQ = (rxLevel >= RX_DEPTH[7:0]);
  wire wrPort = regWrite && (regAddr == `I2CDT_OFF_CMD);
  wire rdPort = regRead && (regAddr == `I2CDT_OFF_CMD);
  wire rdClr = regRead && (regAddr == `I2CDT_OFF_CLR);
  wire [11:0] masked = raw_r & mask_r;

  assign eventIrq = |masked;
  assign cmdValid = cmdPend_r;
  assign cmdIsWrite = cmdWord_r[`I2CDT_CMD_BIT];
  assign cmdByte = cmdWord_r[7:0];
  assign rxPop = rdPort && !rxEmpty;

  // One-word holding stage toward the transmit queue; overflow refuses the write.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdPend_r <= 1'b0;
      cmdWord_r <= 9'h000;
    end else begin
      if (wrPort && !txFull) begin
        cmdPend_r <= 1'b1;
        cmdWord_r <= regWdata[8:0];
      end else if (cmdTake) begin
        cmdPend_r <= 1'b0;
      end
    end
  end

  // Event flags: a set in the same cycle as the clear wins.
  always @* begin
    raw_nxt = rdClr ? 12'h000 : raw_r;
    if (evGenCall) begin
      raw_nxt[`I2CDT_F_GEN_CALL] = 1'b1;
    end
    if (evStart) begin
      raw_nxt[`I2CDT_F_START] = 1'b1;
    end
    if (evStop) begin
      raw_nxt[`I2CDT_F_STOP] = 1'b1;
    end
    if (evActive) begin
      raw_nxt[`I2CDT_F_ACTIVITY] = 1'b1;
    end
    if (evTxNack) begin
      raw_nxt[`I2CDT_F_TX_DONE] = 1'b1;
    end
    if (evTxAbort) begin
      raw_nxt[`I2CDT_F_TX_ABORT] = 1'b1;
    end
    if (evRdReq) begin
      raw_nxt[`I2CDT_F_RD_REQ] = 1'b1;
    end
    raw_nxt[`I2CDT_F_TX_EMPTY] = (txLevel <= txTl_r);
    if (wrPort && txFull) begin
      raw_nxt[`I2CDT_F_TX_OVER] = 1'b1;
    end
    raw_nxt[`I2CDT_F_RX_FULL] = (rxLevel >= rxTl_r);
    if (evRxByte && rxFullQ) begin
      raw_nxt[`I2CDT_F_RX_OVER] = 1'b1;
    end
    if (rdPort && rxEmpty) begin
      raw_nxt[`I2CDT_F_RX_UNDER] = 1'b1;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      raw_r <= 12'h000;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  // Each software register decodes its own offset, so writes elsewhere leave it untouched.
  i2cdt_soft_reg #(
    .WIDTH(16),
    .ADDR(`I2CDT_OFF_SS_HCNT),
    .RST_VAL(`I2CDT_CNT_RST)
  ) u_ssHigh (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(ssHigh_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(16),
    .ADDR(`I2CDT_OFF_SS_LCNT),
    .RST_VAL(`I2CDT_CNT_RST)
  ) u_ssLow (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(ssLow_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(16),
    .ADDR(`I2CDT_OFF_FS_HCNT),
    .RST_VAL(`I2CDT_CNT_RST)
  ) u_fsHigh (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(fsHigh_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(16),
    .ADDR(`I2CDT_OFF_FS_LCNT),
    .RST_VAL(`I2CDT_CNT_RST)
  ) u_fsLow (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(fsLow_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(16),
    .ADDR(`I2CDT_OFF_HS_HCNT),
    .RST_VAL(`I2CDT_CNT_RST)
  ) u_hsHigh (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(hsHigh_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(16),
    .ADDR(`I2CDT_OFF_HS_LCNT),
    .RST_VAL(`I2CDT_CNT_RST)
  ) u_hsLow (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(hsLow_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(`I2CDT_FLAG_W),
    .ADDR(`I2CDT_OFF_MASK),
    .RST_VAL(`I2CDT_MASK_RST)
  ) u_mask (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(mask_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(8),
    .ADDR(`I2CDT_OFF_RXTL),
    .RST_VAL(`I2CDT_TL_RST)
  ) u_rxTl (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(rxTl_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(8),
    .ADDR(`I2CDT_OFF_TXTL),
    .RST_VAL(`I2CDT_TL_RST)
  ) u_txTl (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(txTl_r)
  );

  i2cdt_soft_reg #(
    .WIDTH(3),
    .ADDR(`I2CDT_OFF_CTRL),
    .RST_VAL(`I2CDT_CTRL_RST)
  ) u_ctrl (
    .clk(clk),
    .sys_rst(sys_rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .value_r(ctrl_r)
  );

  // Speed select lives in control bits 2:1; code 0 falls back to standard.
  always @* begin
    speedMode = ctrl_r[2:1];
    case (ctrl_r[2:1])
      `I2CDT_SPD_FAST: begin
        highSel = fsHigh_r;
        lowSel = fsLow_r;
      end
      `I2CDT_SPD_HS: begin
        highSel = hsHigh_r;
        lowSel = hsLow_r;
      end
      default: begin
        highSel = ssHigh_r;
        lowSel = ssLow_r;
      end
    endcase
  end

  // SCL phase timer. A count of zero is taken as one cycle so the clock never stalls.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclOut <= 1'b1;
      phaseCnt_r <= 16'h0000;
    end else if (!sclRun) begin
      sclOut <= 1'b1;
      phaseCnt_r <= 16'h0000;
    end else if (phaseCnt_r + 16'h0001 >= (sclOut ? highSel : lowSel)) begin
      sclOut <= ~sclOut;
      phaseCnt_r <= 16'h0000;
    end else begin
      phaseCnt_r <= phaseCnt_r + 16'h0001;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        `I2CDT_OFF_CMD: regRdata <= {24'h000000, rxByte};
        `I2CDT_OFF_SS_HCNT: regRdata <= {16'h0000, ssHigh_r};
        `I2CDT_OFF_SS_LCNT: regRdata <= {16'h0000, ssLow_r};
        `I2CDT_OFF_FS_HCNT: regRdata <= {16'h0000, fsHigh_r};
        `I2CDT_OFF_FS_LCNT: regRdata <= {16'h0000, fsLow_r};
        `I2CDT_OFF_HS_HCNT: regRdata <= {16'h0000, hsHigh_r};
        `I2CDT_OFF_HS_LCNT: regRdata <= {16'h0000, hsLow_r};
        `I2CDT_OFF_STAT: regRdata <= {20'h00000, masked};
        `I2CDT_OFF_MASK: regRdata <= {20'h00000, mask_r};
        `I2CDT_OFF_RAW: regRdata <= {20'h00000, raw_r};
        `I2CDT_OFF_RXTL: regRdata <= {24'h000000, rxTl_r};
        `I2CDT_OFF_TXTL: regRdata <= {24'h000000, txTl_r};
        `I2CDT_OFF_CLR: regRdata <= {31'h00000000, |raw_r};
        `I2CDT_OFF_CTRL: regRdata <= {29'h00000000, ctrl_r};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

endmodule // i2cdt_regs

// One software-written register with its own offset decode and reset value.
module i2cdt_soft_reg #(
  parameter WIDTH = 16,
  parameter [7:0] ADDR = 8'h00,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  output reg [WIDTH-1:0] value_r
);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_r <= RST_VAL;
    end else if (regWrite && (regAddr == ADDR)) begin
      value_r <= regWdata[WIDTH-1:0];
    end
  end

endmodule // i2cdt_soft_reg
`default_nettype wire

// ### i2cdt_checker.sv
// Port-level assertions for the data, timing and event register block.
`default_nettype none
module i2cdt_checker #(parameter TX_DEPTH = 8) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic cmdValid,
  input wire logic cmdIsWrite,
  input wire logic [7:0] cmdByte,
  input wire logic cmdTake,
  input wire logic [7:0] txLevel,
  input wire logic [7:0] rxLevel,
  input wire logic rxPop,
  input wire logic [7:0] rxByte,
  input wire logic evStart,
  input wire logic sclRun,
  input wire logic sclOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_cmd_word_out: assert property (regWrite && regAddr == 8'h10 && !cmdValid &&
    txLevel < TX_DEPTH |=> cmdValid && cmdIsWrite == $past(regWdata[8])
    && cmdByte == $past(regWdata[7:0])) else $error("command word wrong");
  a_cmd_word_held: assert property (cmdValid && !cmdTake |=> cmdValid && $stable(cmdByte))
    else $error("pending command lost");
  a_tx_overflow: assert property (regWrite && regAddr == 8'h10 && txLevel >= TX_DEPTH
    ##2 regRead && regAddr == 8'h34 |=> regRdata[3]) else $error("overflow flag missing");
  a_start_seen: assert property (evStart ##2 regRead && regAddr == 8'h34 |=> regRdata[10])
    else $error("start flag missing");
  a_pop_strobe: assert property (rxPop == (regRead && regAddr == 8'h10 && rxLevel != 0))
    else $error("pop strobe wrong");
  a_pop_data: assert property (regRead && regAddr == 8'h10 |=> regRdata[7:0] == $past(rxByte))
    else $error("received byte wrong");
  a_rx_underflow: assert property (regRead && regAddr == 8'h10 && rxLevel == 0
    ##2 regRead && regAddr == 8'h34 |=> regRdata[0]) else $error("underflow flag missing");
  a_rdata_idle: assert property (regRdata != 32'h0 |-> $past(regRead))
    else $error("read data outside its cycle");
  a_scl_idle: assert property (!sclRun |=> sclOut) else $error("clock not idle high");
endmodule // i2cdt_checker
bind i2cdt_regs i2cdt_checker #(.TX_DEPTH(TX_DEPTH)) u_chk (.clk, .sys_rst, .regAddr,
  .regWdata, .regWrite, .regRead, .regRdata, .cmdValid, .cmdIsWrite, .cmdByte, .cmdTake,
  .txLevel, .rxLevel, .rxPop, .rxByte, .evStart, .sclRun, .sclOut);
`default_nettype wire

// ### i2cdt_queue_model.sv
// Transmit and receive queues that stand on the far side of the register block.
`default_nettype none
module i2cdt_queue_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic cmdValid,
  input wire logic rxPop,
  input wire logic rxPush,
  input wire logic [7:0] rxIn,
  output logic cmdTake,
  output logic [7:0] txLevel,
  output logic [7:0] rxLevel,
  output logic [7:0] rxByte
);
  logic [7:0] rxq[$];
  logic [7:0] lastByte;
  assign cmdTake = cmdValid && !stall;
  // The transmit side never drains, so the level climbs to full and overflow can be reached.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txLevel <= 8'h00;
      rxq.delete();
      lastByte = 8'h00;
    end else begin
      if (cmdTake) txLevel <= txLevel + 8'h01;
      if (rxPop && rxq.size() != 0) lastByte = rxq.pop_front();
      if (rxPush) rxq.push_back(rxIn);
    end
    rxLevel <= 8'(rxq.size());
    // An empty queue shows the inverted last byte, so stale data never passes for fresh.
    rxByte <= rxq.size() != 0 ? rxq[0] : ~lastByte;
  end
endmodule // i2cdt_queue_model
`default_nettype wire

// ### i2cdt_regs_tb_top.sv
// Self-checking bench for the data, timing and event register block.
`default_nettype none
module i2cdt_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, stall = 0, rxPush = 0, sclRun = 0;
  logic rdPend = 0, cmdValid, cmdIsWrite, cmdTake, rxPop, sclOut, eventIrq;
  logic [7:0] regAddr = 8'h00, rxIn = 8'h00, ev = 8'h00, txLevel, rxLevel, rxByte, cmdByte;
  logic [31:0] regWdata = 32'h0, regRdata, d, cmdQ[$];
  logic [63:0] expQ[$], expNote;
  logic [1:0] speedMode;
  logic [7:0] rxs[8];
  int error_cnt = 0, compares = 0, seed = 64, n, len;
  i2cdt_regs DUT (.clk, .sys_rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .cmdValid, .cmdIsWrite, .cmdByte, .cmdTake, .txLevel, .rxLevel, .rxPop, .rxByte,
    .evGenCall(ev[6]), .evStart(ev[5]), .evStop(ev[4]), .evActive(ev[3]), .evTxNack(ev[2]),
    .evTxAbort(ev[1]), .evRdReq(ev[0]), .evRxByte(ev[7]), .sclRun, .sclOut, .speedMode,
    .eventIrq);
  i2cdt_queue_model partner (.clk, .sys_rst, .stall, .cmdValid, .rxPop, .rxPush, .rxIn,
    .cmdTake, .txLevel, .rxLevel, .rxByte);
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] care);
    compares++;
    if ((got & care) !== (exp & care)) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {regWrite, regAddr, regWdata} <= {1'b1, a, v};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] c = '1);
    @(posedge clk);
    {regRead, regAddr} <= {1'b1, a};
    expQ.push_back({c, e});
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task automatic sclRunLen(input logic v, output int k);
    k = 0;
    while (sclOut !== v && k < 99) begin @(posedge clk); k++; end
    k = 0;
    while (sclOut === v && k < 99) begin @(posedge clk); k++; end
  endtask
  task automatic stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken exactly there.
  always @(posedge clk) begin
    rdPend <= regRead;
    if (rdPend) begin
      expNote = expQ.pop_front();
      chk(regRdata, expNote[31:0], expNote[63:32]);
    end
    if (cmdValid && cmdTake) chk({23'h0, cmdIsWrite, cmdByte}, cmdQ.pop_front(), 32'h1FF);
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 6; n++) rd(8'h14 + 8'(4 * n), 32'h0);
    rd(8'h30, 32'h8FF);
    rd(8'h38, 32'h0);
    rd(8'h3C, 32'h0);
    rd(8'h34, 32'h14, 32'h14);
    wr(8'h04, 32'h5A);
    rd(8'h04, 32'h0);
    wr(8'h30, 32'h0);
    @(negedge clk);
    chk(32'(eventIrq), 32'h0, 32'h1);
    wr(8'h30, 32'h4);
    @(negedge clk);
    chk(32'(eventIrq), 32'h1, 32'h1);
    rd(8'h2C, 32'h4);
    wr(8'h30, 32'hFFFFF8FF);
    rd(8'h30, 32'h8FF);
    for (n = 0; n < 6; n++) begin
      d = $random(seed);
      wr(8'h14 + 8'(4 * n), d);
      rd(8'h14 + 8'(4 * n), {16'h0, d[15:0]});
    end
    for (n = 1; n < 4; n++) begin
      wr(8'h0C + 8'(8 * n), n + 1);
      wr(8'h10 + 8'(8 * n), n + 3);
      wr(8'h00, 2 * n);
      sclRun <= 1'b1;
      sclRunLen(1'b0, len);
      chk(len, n + 3, '1);
      chk(32'(speedMode), n, 32'h3);
      sclRunLen(1'b1, len);
      chk(len, n + 1, '1);
      sclRun <= 1'b0;
    end
    stall <= 1'b1;
    for (n = 0; n < 8; n++) begin
      d = $random(seed);
      d[8] = n[0];
      cmdQ.push_back({23'h0, d[8:0]});
      wr(8'h10, d);
      if (n == 0) repeat (3) @(posedge clk);
      stall <= 1'b0;
    end
    wr(8'h10, 32'h1FF);
    rd(8'h34, 32'h8, 32'h18);
    wr(8'h3C, 32'h8);
    rd(8'h34, 32'h10, 32'h10);
    for (n = 0; n < 7; n++) begin
      @(posedge clk);
      ev <= 8'h01 << n;
      @(posedge clk);
      ev <= 8'h00;
      rd(8'h34, 32'h20 << n, 32'h20 << n);
    end
    rd(8'h40, 32'h1, 32'h1);
    rd(8'h34, 32'h0, 32'hFEB);
    wr(8'h38, 32'h8);
    rd(8'h34, 32'h0, 32'h4);
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      rxs[n] = 8'($random(seed));
      {rxPush, rxIn} <= {1'b1, rxs[n]};
    end
    @(posedge clk);
    rxPush <= 1'b0;
    ev <= 8'h80;
    @(posedge clk);
    ev <= 8'h00;
    rd(8'h34, 32'h6, 32'h6);
    for (n = 0; n < 8; n++) rd(8'h10, {24'h0, rxs[n]});
    rd(8'h10, {24'h0, ~rxs[7]});
    rd(8'h34, 32'h1, 32'h5);
    repeat (3) @(posedge clk);
    stop_test();
  end
  // The tests need well under two thousand cycles; this allows several times that.
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
endmodule // i2cdt_regs_tb_top
`default_nettype wire
